/* design/fhr_consts.svh */
// Offsets, field positions and reset values of the floppy host register set
`ifndef FHR_CONSTS_SVH
`define FHR_CONSTS_SVH

`define FHR_OFF_STAT_A      3'h0
`define FHR_OFF_STAT_B      3'h1
`define FHR_OFF_DRV_OUT     3'h2
`define FHR_OFF_TAPE        3'h3
`define FHR_OFF_MAIN_RATE   3'h4
`define FHR_OFF_DATA        3'h5
`define FHR_OFF_DIAG_CTRL   3'h7

`define FHR_DO_DSEL_LO      0
`define FHR_DO_DSEL_HI      1
`define FHR_DO_CTRL_RUN     2
`define FHR_DO_DMA_EN       3
`define FHR_DO_MOTOR_A      4
`define FHR_DO_MOTOR_B      5
`define FHR_DO_MOTOR_C      6
`define FHR_DO_MOTOR_D      7

`define FHR_DR_SW_RESET     7
`define FHR_DR_POWER_DOWN   6
`define FHR_DR_PRE_HI       4
`define FHR_DR_PRE_LO       2
`define FHR_CC_NO_CODE_A   2

`define FHR_RATE_RESET      2'h2
`define FHR_PRE_RESET       3'h0
`define FHR_BYTE_ZERO       8'h00
`define FHR_BYTE_ONES       8'hFF

`define FHR_PRE_DEFAULT     3'h0
`define FHR_PRE_OFF         3'h7
`define FHR_PRE_STEP_PS     41670
`define FHR_PRE_DEF_LOW_PS  125000
`define FHR_PRE_DEF_1M_PS   41670
`define FHR_PRE_DEF_2M_PS   20800
`define FHR_PRE_DEF_CODE    3'h3
`define FHR_PRE_DEF_1M_CODE 3'h1

`define FHR_TAPE_RATE_2M    2'h2
`define FHR_RATE_1M         2'h3
`define FHR_RATE_500K       2'h0

`endif

/* design/fhr_pkg.sv */
// Types shared by the floppy host register set
package fhr_pkg;

    typedef enum logic [1:0] {
        FHR_MODE_BASIC,
        FHR_MODE_SYS_A,
        FHR_MODE_SYS_B
    } fhr_mode_t;

    typedef struct packed {
        logic write_data_pin_n;
        logic read_data_pin_n;
        logic write_gate_pin_n;
        logic step_pin_n;
        logic motor_a_on_n;
        logic motor_b_on_n;
        logic select_drive_a_n;
        logic select_drive_b_n;
        logic select_drive_c_n;
        logic select_drive_d_n;
        logic head_sel_n;
        logic dir_inward;
        logic write_protect_n;
        logic track0_n;
        logic index_n;
        logic disk_changed_n;
        logic second_drive_present_n;
        logic irq;
        logic drq;
    } fhr_pins_t;

    typedef struct packed {
        logic       three_mode_enable;
        logic [7:0] chip_config_7;
        logic [3:0] chip_config_8;
        logic [1:0] tape_rate;
    } fhr_cfg_t;

    typedef struct packed {
        logic [1:0] rate_code;
        logic [2:0] code_a_code;
        logic       reduced_write_current_n;
        logic       power_down;
        logic       fifo_enable;
    } fhr_ctrl_t;

endpackage

/* design/fhr_pin_latch.sv */
// Toggle and latch cells that watch drive interface pins
`timescale 1ns/1ps
`default_nettype none
module fhr_pin_latch
    import fhr_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    input  wire logic i_wd_n,
    input  wire logic i_rd_n,
    input  wire logic i_wg_n,
    input  wire logic i_step_n,
    output logic      o_wd_toggle,
    output logic      o_rd_toggle,
    output logic      o_wd_latch,
    output logic      o_rd_latch,
    output logic      o_wg_latch,
    output logic      o_step_latch
);
    typedef struct packed {
        logic wd_prev;
        logic rd_prev;
        logic wd_tog;
        logic rd_tog;
        logic wd_lat;
        logic rd_lat;
        logic wg_lat;
        logic step_lat;
    } fhr_latch_st_t;

    fhr_latch_st_t st_q;
    fhr_latch_st_t st_d;

    always_comb begin
        st_d         = st_q;
        st_d.wd_prev = i_wd_n;
        st_d.rd_prev = i_rd_n;
        if (i_wd_n && !st_q.wd_prev) begin
            st_d.wd_tog = !st_q.wd_tog;
            st_d.wd_lat = 1'b1;
        end
        if (i_rd_n && !st_q.rd_prev) begin
            st_d.rd_tog = !st_q.rd_tog;
        end
        if (!i_rd_n) begin
            st_d.rd_lat = 1'b1;
        end
        if (!i_wg_n) begin
            st_d.wg_lat = 1'b1;
        end
        if (!i_step_n) begin
            st_d.step_lat = 1'b1;
        end
        if (i_clear) begin
            st_d.wd_lat   = 1'b0;
            st_d.rd_lat   = 1'b0;
            st_d.wg_lat   = 1'b0;
            st_d.step_lat = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '{wd_prev: 1'b1, rd_prev: 1'b1, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_wd_toggle  = st_q.wd_tog;
    assign o_rd_toggle  = st_q.rd_tog;
    assign o_wd_latch   = st_q.wd_lat;
    assign o_rd_latch   = st_q.rd_lat;
    assign o_wg_latch   = st_q.wg_lat;
    assign o_step_latch = st_q.step_lat;
endmodule
`default_nettype wire

/* design/fhr_code_a.sv */
// Write precompensation delay selection from code and data rate
`include "fhr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fhr_code_a
    import fhr_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_code,
    input  wire logic [1:0] i_rate,
    input  wire logic [1:0] i_tape_rate,
    output logic [2:0]      o_steps,
    output logic            o_half_step,
    output logic            o_enable
);
    typedef struct packed {
        logic [2:0] steps;
        logic       half;
        logic       en;
    } fhr_pc_st_t;

    fhr_pc_st_t st_q;
    fhr_pc_st_t st_d;
    logic       tape_2m;

    always_comb begin
        tape_2m  = (i_rate == 2'h1) && (i_tape_rate == `FHR_TAPE_RATE_2M);
        st_d     = st_q;
        st_d.half = tape_2m;
        st_d.en   = (i_code != `FHR_PRE_OFF);
        if (i_code == `FHR_PRE_OFF) begin
            st_d.steps = 3'h0;
        end else if (i_code != `FHR_PRE_DEFAULT) begin
            st_d.steps = i_code;
        end else if (tape_2m || i_rate == `FHR_RATE_1M) begin
            st_d.steps = `FHR_PRE_DEF_1M_CODE;
        end else begin
            st_d.steps = `FHR_PRE_DEF_CODE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_steps     = st_q.steps;
    assign o_half_step = st_q.half;
    assign o_enable    = st_q.en;
endmodule
`default_nettype wire

/* design/fhr_regs.sv */
// Host register set of the floppy controller
//
// Summary of operation
// - Mode B status A: bit1 high when write protected, bit0 high outward.
// - Mode A status B bit5 shows output register drive select bit 0.
// - Mode A status B bits 4/3 toggle on write/read data rising edges.
// - Mode A status B bits 2..0 show inverted write gate, motor B, motor A.
// - Mode B status B bit7 low with second drive; bits 6/5 show selects B/A.
// - Mode B status B bits 4..2 show inverted latched write/read data, gate.
// - Mode B status B bits 1/0 low when drive D/C selected.
// - Drive output register is write-only and cleared by master reset.
// - Tape register holds only bits 1:0 unless three-mode enabled.
// - Three-mode: bits 7:6 from config 8 bits 3:2, bits 3:2 from 1:0.
// - Tape bits 5:4 show config 7 pair of last selected drive.
// - Tape bits 1:0 pick tape drive 1..3, zero means none.
// - Effective rate is whichever rate write came last.
// - Rate register bit7 software reset, bit6 power-down.
// - Rate bits 4:2 select precompensation; 111 off, 000 default.
// - Default delay 125 ns below 1 MB/s, 41.67 at 1M, 20.8 at 2M.
// - Rate codes 00..11 give 500,300,250,1000 KB/s; reduced current 1,0,0,1.
// - Data port leaves reset with FIFO off; only configure enables it.
// - Basic mode input register drives bit7 only, others undriven.
// - Mode A input register: change, ones, rate, high-density flag.
// - Mode B input register: ~change, ones, DMA enable, no-code_a, rate.
// - Mode B status A bits 7/6 show interrupt/request, bit5 inverted latched step.
`include "fhr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fhr_regs
    import fhr_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire fhr_mode_t  i_mode,
    input  wire logic [2:0] i_addr,
    input  wire logic       i_rd_en,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wdata,
    input  wire fhr_pins_t  i_pins,
    input  wire fhr_cfg_t   i_cfg,
    input  wire logic [7:0] i_main_status,
    input  wire logic [7:0] i_data_rd,
    input  wire logic       i_fifo_cfg_wr,
    input  wire logic       i_fifo_cfg_en,
    output logic [7:0]      o_rdata,
    output logic [7:0]      o_rdata_oe,
    output logic            o_data_rd_stb,
    output logic            o_data_wr_stb,
    output logic [7:0]      o_data_wr,
    output logic [7:0]      o_drive_motor_output,
    output logic            o_ctrl_reset,
    output fhr_ctrl_t       o_ctrl,
    output logic [1:0]      o_tape_drive,
    output logic [2:0]      o_code_a_steps,
    output logic            o_code_a_half,
    output logic            o_code_a_en
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dout;
        logic [1:0] tape_sel;
        logic [1:0] rate;
        logic [2:0] code_a;
        logic       power_down;
        logic       sw_reset;
        logic       no_code_a;
        logic       fifo_en;
        logic [7:0] rdata;
        logic [7:0] rdata_oe;
        logic [7:0] wr_data;
        logic       data_rd;
        logic       data_wr;
    } fhr_regs_st_t;

    fhr_regs_st_t st_q;
    fhr_regs_st_t st_d;

    logic       wd_tog;
    logic       rd_tog;
    logic       wd_lat;
    logic       rd_lat;
    logic       wg_lat;
    logic       step_lat;
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic [7:0] tape_rd;
    logic [7:0] diag_rd;
    logic [1:0] dtype;
    logic       rd_stat_a;

    // ------------------------------------------------------------
    // Pin watchers and precompensation
    // ------------------------------------------------------------
    assign rd_stat_a = i_rd_en && (i_addr == `FHR_OFF_STAT_A);

    fhr_pin_latch u_latch (
        .i_sys_clk    (i_sys_clk),
        .i_rst_n      (i_rst_n),
        .i_clear      (!st_q.dout[`FHR_DO_CTRL_RUN]),
        .i_wd_n       (i_pins.write_data_pin_n),
        .i_rd_n       (i_pins.read_data_pin_n),
        .i_wg_n       (i_pins.write_gate_pin_n),
        .i_step_n     (i_pins.step_pin_n),
        .o_wd_toggle  (wd_tog),
        .o_rd_toggle  (rd_tog),
        .o_wd_latch   (wd_lat),
        .o_rd_latch   (rd_lat),
        .o_wg_latch   (wg_lat),
        .o_step_latch (step_lat)
    );

    fhr_code_a u_code_a (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_code      (st_q.code_a),
        .i_rate      (st_q.rate),
        .i_tape_rate (i_cfg.tape_rate),
        .o_steps     (o_code_a_steps),
        .o_half_step (o_code_a_half),
        .o_enable    (o_code_a_en)
    );

    // ------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------
    always_comb begin
        // Status A
        if (i_mode == FHR_MODE_SYS_B) begin
            stat_a = {i_pins.irq, i_pins.drq, !step_lat,
                      !i_pins.track0_n, i_pins.head_sel_n, !i_pins.index_n,
                      !i_pins.write_protect_n,
                      !i_pins.dir_inward};
        end else begin
            stat_a = {i_pins.irq, i_pins.second_drive_present_n, !i_pins.step_pin_n,
                      i_pins.track0_n, !i_pins.head_sel_n, i_pins.index_n,
                      i_pins.write_protect_n, i_pins.dir_inward};
        end
        // Status B
        if (i_mode == FHR_MODE_SYS_B) begin
            stat_b = {i_pins.second_drive_present_n,
                      i_pins.select_drive_b_n, i_pins.select_drive_a_n,
                      !wd_lat, !rd_lat, !wg_lat,
                      i_pins.select_drive_d_n, i_pins.select_drive_c_n};
        end else begin
            stat_b = {2'b11, st_q.dout[`FHR_DO_DSEL_LO],
                      wd_tog, rd_tog,
                      !i_pins.write_gate_pin_n, !i_pins.motor_b_on_n,
                      !i_pins.motor_a_on_n};
        end
        // Tape and media
        unique case (st_q.dout[`FHR_DO_DSEL_HI:`FHR_DO_DSEL_LO])
            2'h0:    dtype = i_cfg.chip_config_7[1:0];
            2'h1:    dtype = i_cfg.chip_config_7[3:2];
            2'h2:    dtype = i_cfg.chip_config_7[5:4];
            default: dtype = i_cfg.chip_config_7[7:6];
        endcase
        if (i_cfg.three_mode_enable) begin
            tape_rd = {i_cfg.chip_config_8[3:2], dtype,
                       i_cfg.chip_config_8[1:0], st_q.tape_sel};
        end else begin
            tape_rd = {6'h00, st_q.tape_sel};
        end
        // Diagnostic input
        unique case (i_mode)
            FHR_MODE_SYS_A: diag_rd = {!i_pins.disk_changed_n, 4'hF,
                                       st_q.rate,
                                       !(st_q.rate == `FHR_RATE_500K ||
                                         st_q.rate == `FHR_RATE_1M)};
            FHR_MODE_SYS_B: diag_rd = {i_pins.disk_changed_n, 3'h7,
                                       st_q.dout[`FHR_DO_DMA_EN],
                                       st_q.no_code_a, st_q.rate};
            default:        diag_rd = {!i_pins.disk_changed_n, 7'h00};
        endcase
    end

    // ------------------------------------------------------------
    // Bus decode and register updates
    // ------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.data_rd  = 1'b0;
        st_d.data_wr  = 1'b0;
        st_d.sw_reset = 1'b0;
        if (i_fifo_cfg_wr) begin
            st_d.fifo_en = i_fifo_cfg_en;
        end
        if (i_wr_en) begin
            unique case (i_addr)
                `FHR_OFF_DRV_OUT: st_d.dout = i_wdata;
                `FHR_OFF_TAPE:    st_d.tape_sel = i_wdata[1:0];
                `FHR_OFF_MAIN_RATE: begin
                    st_d.rate       = i_wdata[1:0];
                    st_d.code_a    = i_wdata[`FHR_DR_PRE_HI:`FHR_DR_PRE_LO];
                    st_d.power_down = i_wdata[`FHR_DR_POWER_DOWN];
                    st_d.sw_reset   = i_wdata[`FHR_DR_SW_RESET];
                end
                `FHR_OFF_DATA: begin
                    st_d.data_wr = 1'b1;
                    st_d.wr_data = i_wdata;
                end
                `FHR_OFF_DIAG_CTRL: begin
                    st_d.rate = i_wdata[1:0];
                    if (i_mode == FHR_MODE_SYS_B) begin
                        st_d.no_code_a = i_wdata[`FHR_CC_NO_CODE_A];
                    end
                end
                default: ;
            endcase
        end
        st_d.rdata    = `FHR_BYTE_ZERO;
        st_d.rdata_oe = `FHR_BYTE_ZERO;
        if (i_rd_en) begin
            st_d.rdata_oe = `FHR_BYTE_ONES;
            unique case (i_addr)
                `FHR_OFF_STAT_A:    st_d.rdata = stat_a;
                `FHR_OFF_STAT_B:    st_d.rdata = stat_b;
                `FHR_OFF_TAPE:      st_d.rdata = tape_rd;
                `FHR_OFF_MAIN_RATE: st_d.rdata = i_main_status;
                `FHR_OFF_DATA: begin
                    st_d.rdata   = i_data_rd;
                    st_d.data_rd = 1'b1;
                end
                `FHR_OFF_DIAG_CTRL: begin
                    st_d.rdata = diag_rd;
                    if (i_mode == FHR_MODE_BASIC) begin
                        st_d.rdata_oe = 8'h80;
                    end
                end
                default: st_d.rdata_oe = `FHR_BYTE_ZERO;
            endcase
            if (rd_stat_a && i_mode == FHR_MODE_BASIC) begin
                st_d.rdata_oe = `FHR_BYTE_ZERO;
            end
        end
        if (st_q.sw_reset) begin
            st_d.fifo_en = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '{rate: `FHR_RATE_RESET, code_a: `FHR_PRE_RESET,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata                        = st_q.rdata;
    assign o_rdata_oe                     = st_q.rdata_oe;
    assign o_data_rd_stb                  = st_q.data_rd;
    assign o_data_wr_stb                  = st_q.data_wr;
    assign o_data_wr                      = st_q.wr_data;
    assign o_drive_motor_output           = st_q.dout;
    assign o_ctrl_reset                   = !st_q.dout[`FHR_DO_CTRL_RUN] || st_q.sw_reset;
    assign o_ctrl.rate_code               = st_q.rate;
    assign o_ctrl.code_a_code            = st_q.code_a;
    assign o_ctrl.reduced_write_current_n = (st_q.rate == `FHR_RATE_500K) ||
                                            (st_q.rate == `FHR_RATE_1M);
    assign o_ctrl.power_down              = st_q.power_down;
    assign o_ctrl.fifo_enable             = st_q.fifo_en;
    assign o_tape_drive                   = st_q.tape_sel;
endmodule
`default_nettype wire

/* tb/fhr_regs_monitor.sv */
// Concurrent checks on the floppy host register set ports
`timescale 1ns/1ps
`default_nettype none
module fhr_regs_monitor
    import fhr_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire fhr_mode_t  i_mode,
    input wire logic [2:0] i_addr,
    input wire logic       i_rd_en,
    input wire logic       i_wr_en,
    input wire logic [7:0] i_wdata,
    input wire fhr_pins_t  i_pins,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_rdata_oe,
    input wire logic [7:0] o_drive_motor_output,
    input wire logic       o_ctrl_reset,
    input wire fhr_ctrl_t  o_ctrl,
    input wire logic [1:0] o_tape_drive,
    input wire logic       o_code_a_en
);
    // ----------------------------------------
    // Decode helpers and sequences
    // ----------------------------------------
    logic wr_do;
    logic wr_dr;
    logic rd_on;
    assign wr_do = i_wr_en && i_addr == 3'h2;
    assign wr_dr = i_wr_en && i_addr == 3'h4;
    assign rd_on = i_rd_en;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_pre_off;
        wr_dr && i_wdata[4:2] == 3'h7;
    endsequence
    sequence s_basic_diag;
        rd_on && i_addr == 3'h7 && i_mode == FHR_MODE_BASIC;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_read_bus_idle: assert property (!rd_on |=> o_rdata_oe == 8'h00)
        else $error("bus driven without read");
    a_rate_dr_load: assert property (wr_dr |=> o_ctrl.rate_code == $past(i_wdata[1:0]))
        else $error("rate not loaded");
    a_rwc_from_rate: assert property (o_ctrl.reduced_write_current_n ==
        (o_ctrl.rate_code == 2'h0 || o_ctrl.rate_code == 2'h3))
        else $error("write current level wrong");
    a_out_reg_load: assert property (wr_do |=> o_drive_motor_output == $past(i_wdata))
        else $error("output register not loaded");
    a_out_reg_hold: assert property (!wr_do |=> $stable(o_drive_motor_output))
        else $error("output register changed");
    a_diag_basic_bit: assert property (s_basic_diag |=>
        o_rdata_oe == 8'h80 && o_rdata[7] == !$past(i_pins.disk_changed_n))
        else $error("basic input read wrong");
    a_sel_bit_shown: assert property (rd_on && i_addr == 3'h1 && i_mode == FHR_MODE_SYS_A
        |=> o_rdata[5] == $past(o_drive_motor_output[0]))
        else $error("select bit wrong");
    a_code_a_off: assert property (s_pre_off |-> ##2 !o_code_a_en)
        else $error("code_a not off");
    a_soft_reset: assert property (wr_dr && i_wdata[7] |=> o_ctrl_reset)
        else $error("soft reset missing");
    a_tape_load: assert property (i_wr_en && i_addr == 3'h3
        |=> o_tape_drive == $past(i_wdata[1:0]))
        else $error("tape select not loaded");
endmodule
bind fhr_regs fhr_regs_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_mode(i_mode), .i_addr(i_addr), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en),
    .i_wdata(i_wdata), .i_pins(i_pins), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe),
    .o_drive_motor_output(o_drive_motor_output), .o_ctrl_reset(o_ctrl_reset),
    .o_ctrl(o_ctrl), .o_tape_drive(o_tape_drive), .o_code_a_en(o_code_a_en));
`default_nettype wire

/* tb/fhr_drive_model.sv */
// Drive side pin model for the floppy host register set
`timescale 1ns/1ps
`default_nettype none
module fhr_drive_model
    import fhr_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire fhr_pins_t i_levels,
    input  wire logic      i_wd_go,
    input  wire logic      i_rd_go,
    output var fhr_pins_t  o_pins
);
    // ----------------------------------------
    // Pins follow levels; a go drops a data line one cycle
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        o_pins <= i_levels;
        if (i_wd_go)
            o_pins.write_data_pin_n <= 1'b0;
        if (i_rd_go)
            o_pins.read_data_pin_n <= 1'b0;
    end
endmodule
`default_nettype wire

/* tb/fhr_regs_bench.sv */
// Self-checking bench for the floppy host register set
`timescale 1ns/1ps
`default_nettype none
module fhr_regs_bench;
    import fhr_pkg::*;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_rd_en = 1'b0, i_wr_en = 1'b0;
    logic i_fifo_cfg_wr = 1'b0, i_fifo_cfg_en = 1'b0, wd_go = 1'b0, rd_go = 1'b0;
    fhr_mode_t  i_mode = FHR_MODE_SYS_A;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, i_main_status = 8'hA5, i_data_rd = 8'h00;
    fhr_pins_t  lv = '1;
    fhr_pins_t  i_pins;
    fhr_cfg_t   i_cfg = '0;
    logic [7:0] o_rdata, o_rdata_oe, o_data_wr, o_drive_motor_output;
    logic       o_data_rd_stb, o_data_wr_stb, o_ctrl_reset, o_code_a_half, o_code_a_en;
    fhr_ctrl_t  o_ctrl;
    logic [1:0] o_tape_drive;
    logic [2:0] o_code_a_steps;
    int         n_fail = 0;
    int         cmp_count = 0;
    always #20 i_sys_clk = ~i_sys_clk;
    fhr_drive_model u_drv (.i_sys_clk(i_sys_clk), .i_levels(lv), .i_wd_go(wd_go),
        .i_rd_go(rd_go), .o_pins(i_pins));
    fhr_regs dut (.*);
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge i_sys_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_mode_a_pins;
        logic [7:0] v;
        @(posedge i_sys_clk);
        lv.motor_a_on_n <= 1'b0;
        wr(3'h2, 8'h1D);
        chk("out reg", o_drive_motor_output, 8'h1D);
        rd(3'h1);
        chk("sel0", {7'h00, o_rdata[5]}, 8'h01);
        chk("motor gate", {5'h00, o_rdata[2:0]}, 8'h01);
        v = o_rdata;
        @(posedge i_sys_clk);
        wd_go <= 1'b1;
        rd_go <= 1'b1;
        @(posedge i_sys_clk);
        wd_go <= 1'b0;
        rd_go <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        rd(3'h1);
        chk("toggles", {6'h00, o_rdata[4:3]}, {6'h00, ~v[4:3]});
    endtask
    task automatic t_mode_b_pins;
        @(posedge i_sys_clk);
        i_mode <= FHR_MODE_SYS_B;
        lv.write_protect_n <= 1'b0;
        lv.drq <= 1'b0;
        lv.second_drive_present_n <= 1'b0;
        lv.select_drive_b_n <= 1'b0;
        lv.select_drive_d_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        rd(3'h0);
        chk("stat a", {3'h0, o_rdata[7:5], o_rdata[1:0]}, 8'h16);
        rd(3'h1);
        chk("stat b", o_rdata, 8'h25);
    endtask
    task automatic t_rate;
        for (int c = 0; c < 4; c++) begin
            wr(3'h4, 8'(c));
            chk("rate", {6'h00, o_ctrl.rate_code}, 8'(c));
            chk("rwc", {7'h00, o_ctrl.reduced_write_current_n}, {7'h00, c == 0 || c == 3});
        end
        wr(3'h7, 8'h01);
        chk("cc rate", {6'h00, o_ctrl.rate_code}, 8'h01);
    endtask
    task automatic t_diag;
        @(posedge i_sys_clk);
        i_mode <= FHR_MODE_SYS_A;
        lv.disk_changed_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        rd(3'h7);
        chk("diag a", o_rdata, 8'hFB);
        chk("diag a oe", o_rdata_oe, 8'hFF);
        wr(3'h7, 8'h00);
        rd(3'h7);
        chk("diag a hd", o_rdata, 8'hF8);
        @(posedge i_sys_clk);
        i_mode <= FHR_MODE_BASIC;
        rd(3'h7);
        chk("diag basic", {o_rdata_oe[6:0], o_rdata[7]}, 8'h01);
        @(posedge i_sys_clk);
        i_mode <= FHR_MODE_SYS_B;
        wr(3'h2, 8'h0C);
        wr(3'h7, 8'h06);
        rd(3'h7);
        chk("diag b", o_rdata, 8'h7E);
        rd(3'h4);
        chk("main stat", o_rdata, 8'hA5);
        rd(3'h6);
        chk("hole oe", o_rdata_oe, 8'h00);
        wr(3'h5, 8'h3C);
        chk("data wr", o_data_wr, 8'h3C);
        rd(3'h5);
        chk("data stb", {6'h00, o_data_rd_stb, o_data_wr_stb}, 8'h02);
    endtask
    task automatic t_code_a;
        logic [15:0] pt [4] = '{16'h000B, 16'h0309, 16'h080A, 16'h0519};
        for (int i = 0; i < 4; i++) begin
            @(posedge i_sys_clk);
            i_cfg.tape_rate <= (i == 3) ? 2'h2 : 2'h0;
            wr(3'h4, pt[i][15:8]);
            @(posedge i_sys_clk);
            #1;
            chk("code_a", {3'h0, o_code_a_half, o_code_a_en, o_code_a_steps},
                pt[i][7:0]);
        end
        wr(3'h4, 8'h1C);
        @(posedge i_sys_clk);
        #1;
        chk("code_a off", {7'h00, o_code_a_en}, 8'h00);
    endtask
    task automatic t_soft_reset;
        @(posedge i_sys_clk);
        i_fifo_cfg_wr <= 1'b1;
        i_fifo_cfg_en <= 1'b1;
        @(posedge i_sys_clk);
        i_fifo_cfg_wr <= 1'b0;
        #1;
        chk("fifo on", {7'h00, o_ctrl.fifo_enable}, 8'h01);
        wr(3'h4, 8'h40);
        chk("power down", {7'h00, o_ctrl.power_down}, 8'h01);
        wr(3'h4, 8'h80);
        chk("sw reset", {7'h00, o_ctrl_reset}, 8'h01);
        @(posedge i_sys_clk);
        #1;
        chk("fifo off", {7'h00, o_ctrl.fifo_enable}, 8'h00);
    endtask
    task automatic t_tape;
        @(posedge i_sys_clk);
        i_cfg.three_mode_enable <= 1'b1;
        i_cfg.chip_config_8 <= 4'h9;
        i_cfg.chip_config_7 <= 8'hE4;
        wr(3'h2, 8'h0E);
        for (int c = 0; c < 4; c++) begin
            wr(3'h3, 8'(c));
            chk("tape sel", {6'h00, o_tape_drive}, 8'(c));
        end
        rd(3'h3);
        chk("tape 3mode", o_rdata, 8'hA7);
        @(posedge i_sys_clk);
        i_cfg.three_mode_enable <= 1'b0;
        rd(3'h3);
        chk("tape plain", o_rdata, 8'h03);
    endtask
    task automatic t_master_reset;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        #1;
        chk("reset out", o_drive_motor_output, 8'h00);
        chk("reset ctl", {o_ctrl.rate_code, 5'h00, o_ctrl.fifo_enable}, 8'h80);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        #1;
        chk("ctl reset", {7'h00, o_ctrl_reset}, 8'h01);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_mode_a_pins;
        t_mode_b_pins;
        t_rate;
        t_diag;
        t_code_a;
        t_soft_reset;
        t_tape;
        t_master_reset;
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
